// file: hdl/bus_hold_ctrl.sv
// Purpose: Hold request / acknowledge handshake of the primary external bus.
// Assumes: Requester obeys minimum request width and waits for acknowledge.
// Notes: Core stalls only when it needs the bus and cannot start an access or park a write.
// Summary of operation
// RQ1: Request synchronised; late change costs one cycle.
// RQ2: Inhibit bit exits hold, blocks new holds.
// RQ3: During hold, stall only on bus access.
// RQ4: First write may pend; second write stalls.
// RQ5: Request captured one cycle before cycle end.
// RQ6: Requester holds request wait-states plus three.
// RQ7: Requester releases only after acknowledge seen.
// RQ8: Acknowledge changes on phase falling edges.
// RQ9: Strobe driven high, then floated.
// RQ10: Control/address float on fall, data on rise.
// RQ11: Drivers re-enabled on fall before access.
// RQ12: Acknowledge after cycle done; drive after release.
`timescale 1ns/100ps
module bus_hold_ctrl
	import bus_hold_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic BUS_REQ_N,
	input wire logic GRANT_INHIBIT_BIT,
	input wire logic [WAIT_W-1:0] WAIT_STATE_COUNT,
	input wire core_req_type CORE_REQ,
	output logic CORE_STALL,
	output logic CORE_DONE,
	output logic BUS_GRANT_ACK_N,
	output bus_pins_type BUS_PINS
);
	logic rise_en; // Phase-clock rising edge enable
	logic fall_en; // Phase-clock falling edge enable
	logic req_meta_ff; // First synchroniser stage
	logic req_sync_ff; // Synchronised request, active high
	hold_state_type state_ff; // Hold sequencer
	logic ack_n_ff; // Acknowledge pin register
	logic cyc_ff; // Bus cycle in progress
	logic [WAIT_W-1:0] cyc_cnt_ff; // Phase cycles left in current access
	logic cyc_write_ff; // Current access is a write
	logic pend_ff; // Write parked during a hold
	core_req_type pend_req_ff; // Parked write contents
	logic strobe_n_ff; // Strobe drive value
	logic ctl_oe_n_ff; // Strobe, rw, address enables
	logic data_oe_n_ff; // Data enable
	logic [ADDR_W-1:0] addr_ff; // Address drive value
	logic [DATA_W-1:0] data_ff; // Data drive value
	logic rw_ff; // Read/write drive value, high for read
	logic held; // Bus currently granted away
	logic cyc_last; // Final phase of current access
	logic start_ok; // New access may start now
	core_req_type issue; // Access to launch next

	phase_edge_gen #(.DIV(PHASE_DIV)) u_phase (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.rise_en(rise_en),
		.fall_en(fall_en)
	);

	// Two flops before the request is looked at
	// Only the second stage feeds logic, so metastability stays contained
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			req_meta_ff <= 1'b0;
			req_sync_ff <= 1'b0;
		end else begin
			req_meta_ff <= !BUS_REQ_N; // see RQ1
			req_sync_ff <= req_meta_ff;
		end
	end

	assign held = (state_ff != ST_IDLE) && (state_ff != ST_DRAIN);
	assign cyc_last = cyc_ff && (cyc_cnt_ff == '0);
	// Parked write is replayed before any newer access
	assign issue = pend_ff ? pend_req_ff : CORE_REQ;
	assign start_ok = (state_ff == ST_IDLE) && fall_en && !cyc_ff;

	// Hold sequencer, stepped only on phase falling edges
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state_ff <= ST_IDLE;
		end else if (fall_en) begin
			case (state_ff)
				ST_IDLE: begin
					// Sampled on every phase falling edge while idle, whether or not a cycle is running
					if (req_sync_ff && !GRANT_INHIBIT_BIT) begin // see RQ5 see RQ2
						state_ff <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (GRANT_INHIBIT_BIT) begin // see RQ2
						state_ff <= ST_IDLE;
					end else if (!cyc_ff || cyc_last) begin // see RQ12
						state_ff <= ST_STROBE_HIGH;
					end
				end
				ST_STROBE_HIGH: begin
					// Inhibit arriving this late still cancels the grant
					if (GRANT_INHIBIT_BIT) begin // see RQ2
						state_ff <= ST_RELEASE;
					end else begin
						state_ff <= ST_FLOAT; // see RQ9
					end
				end
				ST_FLOAT: state_ff <= ST_HELD;
				ST_HELD: begin
					// Inhibit forces the hold to end as a release would
					if (!req_sync_ff || GRANT_INHIBIT_BIT) begin // see RQ2 see RQ12
						state_ff <= ST_RELEASE;
					end
				end
				ST_RELEASE: state_ff <= ST_IDLE; // see RQ11
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Acknowledge only moves on falling edges
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ack_n_ff <= 1'b1;
		end else if (fall_en) begin
			if (state_ff == ST_STROBE_HIGH && !GRANT_INHIBIT_BIT) begin
				// No grant once inhibit is up
				ack_n_ff <= 1'b0; // see RQ8 see RQ12
			end else if (state_ff == ST_HELD && (!req_sync_ff || GRANT_INHIBIT_BIT)) begin
				ack_n_ff <= 1'b1; // see RQ8
			end
		end
	end

	// Access sequencing: launch, count wait states, finish
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			cyc_ff <= 1'b0;
			cyc_cnt_ff <= '0;
			cyc_write_ff <= 1'b0;
			addr_ff <= '0;
			data_ff <= '0;
			rw_ff <= 1'b1;
		end else if (fall_en) begin
			if (cyc_last) begin
				cyc_ff <= 1'b0;
			end else if (cyc_ff) begin
				cyc_cnt_ff <= cyc_cnt_ff - 1'b1;
			end else if (start_ok && (issue.req || pend_ff)) begin // see RQ3
				cyc_ff <= 1'b1;
				cyc_cnt_ff <= WAIT_STATE_COUNT + ACCESS_BASE - 1'b1;
				cyc_write_ff <= issue.write;
				addr_ff <= issue.addr;
				data_ff <= issue.wdata;
				rw_ff <= !issue.write;
			end
		end
	end

	// One write may be parked while the bus is away
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			pend_ff <= 1'b0;
			pend_req_ff <= '0;
		end else if (held && CORE_REQ.req && CORE_REQ.write && !pend_ff) begin
			pend_ff <= 1'b1; // see RQ4
			pend_req_ff <= CORE_REQ;
		end else if (start_ok && pend_ff) begin
			pend_ff <= 1'b0;
		end
	end

	// Pin drivers: strobe high first, then float control, data on rise
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			strobe_n_ff <= 1'b1;
			ctl_oe_n_ff <= 1'b0;
			data_oe_n_ff <= 1'b1;
		end else begin
			if (fall_en) begin
				if (state_ff == ST_STROBE_HIGH) begin
					strobe_n_ff <= 1'b1; // see RQ9
				end else if (state_ff == ST_FLOAT) begin
					ctl_oe_n_ff <= 1'b1; // see RQ9 see RQ10
				end else if (state_ff == ST_RELEASE) begin
					ctl_oe_n_ff <= 1'b0; // see RQ11
				end else if (start_ok && (issue.req || pend_ff)) begin
					strobe_n_ff <= 1'b0;
				end else if (cyc_last) begin
					strobe_n_ff <= 1'b1;
				end
			end
			if (rise_en) begin
				// Data lines float on a rising edge during hold
				if (held) begin
					data_oe_n_ff <= 1'b1; // see RQ10
				end else begin
					data_oe_n_ff <= !(cyc_ff && cyc_write_ff);
				end
			end
		end
	end

	// Stall when the core needs the bus and cannot have it
	always_comb begin
		CORE_STALL = 1'b0;
		if (CORE_REQ.req) begin
			if (held || state_ff == ST_RELEASE) begin
				// Reads always stall; writes only once one is parked
				CORE_STALL = !CORE_REQ.write || pend_ff; // see RQ3 see RQ4
			end else begin
				CORE_STALL = !(start_ok && !pend_ff);
			end
		end
	end

	assign CORE_DONE = fall_en && cyc_last;
	assign BUS_GRANT_ACK_N = ack_n_ff;

	// Collect pin drive values
	always_comb begin
		BUS_PINS.strobe_n = strobe_n_ff;
		BUS_PINS.rw = rw_ff;
		BUS_PINS.addr = addr_ff;
		BUS_PINS.data = data_ff;
		BUS_PINS.ctl_oe_n = ctl_oe_n_ff;
		BUS_PINS.data_oe_n = data_oe_n_ff;
	end
endmodule

// file: hdl/bus_hold_pkg.sv
// Purpose: Shared constants and carrier types for the primary-bus hold handshake.
// Assumes: One system clock; phase-clock falling edge modelled as an enable pulse.
// Notes: Pin groups travel as packed structs.
package bus_hold_pkg;
	// Phase divider: system cycles per phase-clock cycle
	localparam int PHASE_DIV = 2;
	// Width of the wait-state count field
	localparam int WAIT_W = 3;
	// Default wait-state count after reset
	localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h0;
	// Address and data widths of the primary bus
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	// Extra phase cycles a bus access takes beyond its wait states
	localparam logic [WAIT_W-1:0] ACCESS_BASE = 3'h1;

	// Hold sequencing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DRAIN,
		ST_STROBE_HIGH,
		ST_FLOAT,
		ST_HELD,
		ST_RELEASE
	} hold_state_type;

	// Internal core access request
	typedef struct packed {
		logic req;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} core_req_type;

	// Bus pin drive values and active-low enables
	typedef struct packed {
		logic strobe_n;
		logic rw;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic ctl_oe_n;
		logic data_oe_n;
	} bus_pins_type;
endpackage

// file: hdl/phase_edge_gen.sv
// Purpose: Produces phase-clock rise and fall enable pulses from the system clock.
// Assumes: Synchronous active-low reset.
// Notes: Fall pulse is the hold sampling point.
`timescale 1ns/100ps
module phase_edge_gen
	import bus_hold_pkg::*;
#(
	parameter int DIV = PHASE_DIV
) (
	input wire logic clk,
	input wire logic rstn,
	output logic rise_en,
	output logic fall_en
);
	// Refuse dividers that give no distinct half phases, at elaboration
	if (DIV < 2 || DIV % 2 != 0) begin : g_div_check
		$error("phase_edge_gen: DIV must be even and at least 2");
	end

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

	logic [CW-1:0] cnt_ff; // Position inside one phase period

	// Free-running divider
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_ff <= '0;
		end else if (cnt_ff == LAST) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Rise at mid period, fall at end of period
	always_comb begin
		rise_en = rstn && (cnt_ff == HALF);
		fall_en = rstn && (cnt_ff == LAST);
	end
endmodule

// file: tb/bus_hold_ctrl_assertions.sv
// Purpose: Port checks for the bus hold handshake.
// Assumes: Requester keeps its timing rules.
// Notes: Bound to the top module.
`timescale 1ns/100ps
module bus_hold_ctrl_assertions
	import bus_hold_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic BUS_REQ_N,
	input wire logic GRANT_INHIBIT_BIT,
	input wire logic [WAIT_W-1:0] WAIT_STATE_COUNT,
	input wire core_req_type CORE_REQ,
	input wire logic CORE_STALL,
	input wire logic CORE_DONE,
	input wire logic BUS_GRANT_ACK_N,
	input wire bus_pins_type BUS_PINS
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// Grant starts and floating starts
	sequence ack_on; $fell(BUS_GRANT_ACK_N); endsequence
	sequence float_on; $rose(BUS_PINS.ctl_oe_n); endsequence
	a_ack_needs_req: assert property (ack_on |-> !$past(BUS_REQ_N, 4))
		else $error("ack without request");
	a_inhibit_blocks: assert property (GRANT_INHIBIT_BIT[*4] ##0 BUS_GRANT_ACK_N |=> BUS_GRANT_ACK_N)
		else $error("ack while inhibited");
	a_inhibit_ends_hold: assert property ($rose(GRANT_INHIBIT_BIT) ##0 !BUS_GRANT_ACK_N |-> ##[1:4] BUS_GRANT_ACK_N)
		else $error("hold kept under inhibit");
	a_ack_phase_step: assert property ($changed(BUS_GRANT_ACK_N) |=> $stable(BUS_GRANT_ACK_N))
		else $error("ack off phase");
	a_strobe_high_first: assert property (ack_on |-> BUS_PINS.strobe_n && !BUS_PINS.ctl_oe_n)
		else $error("strobe not high at ack");
	a_float_after_ack: assert property (ack_on |-> ##[1:4] BUS_PINS.ctl_oe_n)
		else $error("control not floated");
	a_data_float_late: assert property (float_on |-> $past(BUS_PINS.strobe_n) ##[0:3] BUS_PINS.data_oe_n)
		else $error("data not floated");
	a_no_bus_held: assert property (!BUS_GRANT_ACK_N && !$past(BUS_GRANT_ACK_N) |-> !CORE_DONE && BUS_PINS.strobe_n)
		else $error("bus used in hold");
	a_release_after_req: assert property ($rose(BUS_GRANT_ACK_N) |-> $past(BUS_REQ_N, 2) || $past(GRANT_INHIBIT_BIT))
		else $error("ack dropped early");
	a_drive_after_ack: assert property ($fell(BUS_PINS.ctl_oe_n) |-> BUS_GRANT_ACK_N && $past(BUS_GRANT_ACK_N))
		else $error("drive during hold");
	a_read_stalls_held: assert property (!BUS_GRANT_ACK_N && CORE_REQ.req && !CORE_REQ.write |-> CORE_STALL)
		else $error("read taken in hold");
endmodule
bind bus_hold_ctrl bus_hold_ctrl_assertions bus_hold_ctrl_assertions_i(.SYS_CLK(SYS_CLK), .RSTN(RSTN),
	.BUS_REQ_N(BUS_REQ_N), .GRANT_INHIBIT_BIT(GRANT_INHIBIT_BIT), .WAIT_STATE_COUNT(WAIT_STATE_COUNT),
	.CORE_REQ(CORE_REQ), .CORE_STALL(CORE_STALL), .CORE_DONE(CORE_DONE),
	.BUS_GRANT_ACK_N(BUS_GRANT_ACK_N), .BUS_PINS(BUS_PINS));

// file: tb/bus_master_model.sv
// Purpose: Outside master asking for the primary bus.
// Assumes: Acts on falling system edges.
// Notes: Extra lengthens the hold for slow masters.
`timescale 1ns/100ps
module bus_master_model
	import bus_hold_pkg::*;
(
	input wire logic clk,
	input wire logic ack_n,
	input wire logic start,
	input wire logic [7:0] extra,
	input wire logic [WAIT_W-1:0] wait_cnt,
	output logic req_n,
	output logic busy
);
	int held = 0; // Clocks with request low
	int seen = 0; // Clocks with ack low
	initial req_n = 1'b1;
	initial busy = 1'b0;
	// Request kept past minimum width and ack
	always @(negedge clk) begin
		if (start && !busy) begin
			req_n <= 1'b0;
			busy <= 1'b1;
			held <= 0;
			seen <= 0;
		end else if (!req_n) begin
			held <= held + 1;
			seen <= seen + int'(!ack_n);
			if (held >= 2 * (wait_cnt + 3) + extra && seen >= 2)
				req_n <= 1'b1;
		end else
			busy <= 1'b0;
	end
endmodule

// file: tb/external_bus_hold_handshake_bench.sv
// Purpose: Self-checking bench for the bus hold handshake.
// Assumes: Master model owns the request.
// Notes: Inputs change on falling edges.
`timescale 1ns/100ps
module external_bus_hold_handshake_bench;
	import bus_hold_pkg::*;
	logic clk = 0, rstn = 0, inhibit = 0, start = 0, stall, done, ack_n, req_n, busy;
	logic [WAIT_W-1:0] wcnt = 3'h0;
	logic [7:0] extra = 8'h20;
	core_req_type creq = '0;
	bus_pins_type pins;
	int error_cnt = 0, total_checks = 0, done_cnt = 0;
	initial forever #20 clk = ~clk;
	// Completed bus accesses
	always @(posedge clk) if (done === 1'b1) done_cnt <= done_cnt + 1;
	bus_hold_ctrl bus_hold_ctrl_i(.SYS_CLK(clk), .RSTN(rstn), .BUS_REQ_N(req_n), .GRANT_INHIBIT_BIT(inhibit),
		.WAIT_STATE_COUNT(wcnt), .CORE_REQ(creq), .CORE_STALL(stall), .CORE_DONE(done),
		.BUS_GRANT_ACK_N(ack_n), .BUS_PINS(pins));
	bus_master_model bus_master_model_i(.clk(clk), .ack_n(ack_n), .start(start), .extra(extra),
		.wait_cnt(wcnt), .req_n(req_n), .busy(busy));
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Start cleared off the edge so the model cannot miss it
	task kick;
		start = 1'b1;
		tick(1);
		#1 start = 1'b0;
	endtask
	// Bounded wait on the acknowledge level
	task wait_ack(input logic lvl);
		int k;
		k = 0;
		while (ack_n !== lvl && k < 200) begin
			tick(1);
			k++;
		end
		check("ack_n", ack_n, lvl);
	endtask
	task wait_done(input int n);
		int k;
		k = 0;
		while (done_cnt < n && k < 400) begin
			tick(1);
			k++;
		end
		check("done_cnt", done_cnt, n);
	endtask
	// Core request held until the core access is taken
	task core(input logic wr, input logic [31:0] d);
		int k;
		k = 0;
		creq = {1'b1, wr, 24'h000010, d};
		#1;
		while (stall !== 1'b0 && k < 100) begin
			tick(1);
			#1;
			k++;
		end
		check("stall", stall, 1'b0);
		tick(1);
		creq = '0;
	endtask
	task hold_read(input logic [WAIT_W-1:0] w);
		int d;
		wcnt = w;
		d = done_cnt;
		fork
			core(1'b0, 32'h0);
			kick();
		join
		wait_ack(1'b0);
		check("done", done_cnt - d, 1);
		tick(3);
		check("ctl_oe_n", pins.ctl_oe_n, 1'b1);
		check("data_oe_n", pins.data_oe_n, 1'b1);
		creq = {1'b1, 1'b0, 24'h000010, 32'h0};
		#1 check("stall", stall, 1'b1);
		wait_ack(1'b1);
		core(1'b0, 32'h0);
		wait_done(d + 2);
		check("ctl_oe_n", pins.ctl_oe_n, 1'b0);
		check("rw", pins.rw, 1'b1);
		check("addr", pins.addr, 24'h000010);
		$display("hold read test done");
	endtask
	task park_writes;
		int d;
		d = done_cnt;
		kick();
		wait_ack(1'b0);
		creq = {1'b1, 1'b1, 24'h000010, 32'hA5A5A5A5};
		#1 check("stall", stall, 1'b0);
		tick(1);
		creq = {1'b1, 1'b1, 24'h000010, 32'h5A5A5A5A};
		#1 check("stall", stall, 1'b1);
		wait_ack(1'b1);
		core(1'b1, 32'h5A5A5A5A);
		check("done", done_cnt - d, 1);
		check("data", pins.data, 32'h5A5A5A5A);
		check("rw", pins.rw, 1'b0);
		tick(1);
		check("data_oe_n", pins.data_oe_n, 1'b0);
		wait_done(d + 2);
		check("done", done_cnt - d, 2);
		$display("park write test done");
	endtask
	task inhibit_test;
		extra = 8'hFF;
		kick();
		wait_ack(1'b0);
		inhibit = 1'b1;
		tick(4);
		check("ack_n", ack_n, 1'b1);
		while (busy) tick(1);
		extra = 8'h10;
		kick();
		tick(40);
		check("ack_n", ack_n, 1'b1);
		inhibit = 1'b0;
		wait_ack(1'b0);
		wait_ack(1'b1);
		$display("inhibit test done");
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
	initial begin
		tick(3);
		rstn = 1'b1;
		tick(2);
		hold_read(3'h0);
		hold_read(3'h5);
		park_writes();
		inhibit_test();
		finish_test();
	end
endmodule
